// File: verilog/php_defs.svh
// Purpose: constants for the host bus port core
// Assumes: single bus clock, synchronous active-low reset
// Notes: rule summary below
// Overview of operation
// RULE1: sample bus inputs on rising clock edge only
// RULE2: reset low: drivers off, registers cleared, idle
// RULE3: after reset release resume from default state
// RULE4: suspend mode: ignore reset, keep register contents; code ignores only the bus reset, reset_n still clears all
// RULE5: shared lines carry address, then data
// RULE6: command lines carry command, then byte enables
// RULE7: enable bit n covers data byte lane n
// RULE8: even parity over lines, driven one clock later
// RULE9: parity line undriven when not responsible
`ifndef PHP_DEFS_SVH
`define PHP_DEFS_SVH
`define PHP_AD_W 32
`define PHP_CBE_W 4
`define PHP_LANE_W 8
`define PHP_AD_RST 32'h0000_0000
`define PHP_CBE_RST 4'h0
`endif

// File: verilog/php_pkg.sv
// Purpose: types for the host bus port core
// Assumes: php_defs.svh constants
// Notes: none
`include "php_defs.svh"
package php_pkg;
  typedef struct packed {
    logic [`PHP_AD_W-1:0] ad;
    logic [`PHP_CBE_W-1:0] cbe;
  } php_bus_type;
  typedef struct packed {
    logic [`PHP_AD_W-1:0] addr;
    logic [`PHP_CBE_W-1:0] cmd;
    logic [`PHP_AD_W-1:0] data;
    logic [`PHP_CBE_W-1:0] be;
    logic [`PHP_AD_W-1:0] lane_mask;
    logic addr_valid;
    logic data_valid;
  } php_cap_type;
  typedef enum logic [2:0] {
    PHP_IDLE = 3'b001,
    PHP_ADDR = 3'b010,
    PHP_DATA = 3'b100
  } php_state_type;
endpackage

// File: verilog/php_parity.sv
// Purpose: even parity of bus lines, one clock late
// Assumes: inputs are the driven bus values of the current phase
// Notes: enable delayed with the value so both line up
`timescale 1ns/1ps
`include "php_defs.svh"
module php_parity (
  input wire logic clk,
  input wire logic hold_rst,
  input wire php_pkg::php_bus_type bus_in,
  input wire logic drive_en,
  output logic par_out,
  output logic par_oe
);
  import php_pkg::*;
  logic par_reg, par_next, oe_reg, oe_next;
  always_comb begin
    par_next = ^{bus_in.ad, bus_in.cbe}; // [RULE8]
    oe_next = drive_en; // [RULE9]
    if (hold_rst) begin
      par_next = 1'b0;
      oe_next = 1'b0; // [RULE2]
    end
  end
  always_ff @(posedge clk) begin
    par_reg <= par_next;
    oe_reg <= oe_next;
  end
  assign par_out = par_reg;
  assign par_oe = oe_reg;
  // ***************************
  // checks
  // ***************************
  parity_even_a: assert property (@(posedge clk) // [RULE8]
    disable iff (hold_rst)
    oe_reg |-> ^{par_reg, $past(bus_in.ad), $past(bus_in.cbe)} == 1'b0)
    else $error("parity not even");
endmodule

// File: verilog/php_core.sv
// Purpose: host bus front end: capture, lane decode, parity, reset
// Assumes: transaction control decoded elsewhere into phase strobes
// Notes: suspend_en comes from power logic on the same clock
`timescale 1ns/1ps
`include "php_defs.svh"
module php_core (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic host_bus_reset_n,
  input wire logic suspend_en,
  input wire logic addr_phase,
  input wire logic data_phase,
  input wire logic drive_addr,
  input wire logic drive_data,
  input wire logic par_resp,
  input wire php_pkg::php_bus_type bus_in,
  input wire php_pkg::php_bus_type tx_bus,
  output php_pkg::php_bus_type bus_out,
  output logic ad_oe,
  output logic cbe_oe,
  output logic par_out,
  output logic par_oe,
  output php_pkg::php_cap_type cap,
  output logic active
);
  import php_pkg::*;
  // ***************************
  // input synchronisers
  // ***************************
  // pin is not timed to clk, so two flops before any use
  // reset to the pin's idle level: no false bus reset on release
  logic rst_s1_reg, rst_s1_next, rst_s2_reg, rst_s2_next;
  always_comb begin
    rst_s1_next = host_bus_reset_n;
    rst_s2_next = rst_s1_reg;
    if (!reset_n) begin
      rst_s1_next = 1'b1;
      rst_s2_next = 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    rst_s1_reg <= rst_s1_next;
    rst_s2_reg <= rst_s2_next;
  end
  // ***************************
  // reset qualification
  // ***************************
  // suspend keeps state through a bus reset
  // limitation: reset_n still clears everything in suspend
  logic hold_rst;
  assign hold_rst = !reset_n || (!rst_s2_reg && !suspend_en); // [RULE4]
  // ***************************
  // lane decode
  // ***************************
  function automatic logic [`PHP_AD_W-1:0] lane_mask(
    input logic [`PHP_CBE_W-1:0] be_n
  );
    lane_mask = '0;
    for (int i = 0; i < `PHP_CBE_W; i++) begin
      // active-low enables: low means lane carries data
      lane_mask[i*`PHP_LANE_W +: `PHP_LANE_W] = {`PHP_LANE_W{!be_n[i]}};
    end
  endfunction
  // ***************************
  // phase capture
  // ***************************
  php_state_type state_reg, state_next;
  php_cap_type cap_reg, cap_next;
  logic active_reg, active_next;
  always_comb begin
    state_next = state_reg;
    cap_next = cap_reg;
    // valid bits are one-cycle pulses
    cap_next.addr_valid = 1'b0;
    cap_next.data_valid = 1'b0;
    case (state_reg)
      PHP_IDLE, PHP_ADDR, PHP_DATA: begin
        // address phase wins if both strobes are up
        if (addr_phase) begin
          cap_next.addr = bus_in.ad; // [RULE5]
          cap_next.cmd = bus_in.cbe; // [RULE6]
          cap_next.addr_valid = 1'b1;
          state_next = PHP_ADDR;
        end else if (data_phase) begin
          cap_next.data = bus_in.ad; // [RULE5]
          cap_next.be = bus_in.cbe; // [RULE6]
          cap_next.lane_mask = lane_mask(bus_in.cbe); // [RULE7]
          cap_next.data_valid = 1'b1;
          state_next = PHP_DATA;
        end else begin
          state_next = PHP_IDLE;
        end
      end
      default: state_next = PHP_IDLE;
    endcase
    if (hold_rst) begin
      state_next = PHP_IDLE; // [RULE3]
      cap_next = '0; // [RULE2]
    end
    // registered so the flag leaves straight from a flop
    active_next = state_next != PHP_IDLE;
  end
  always_ff @(posedge clk) begin // [RULE1]
    state_reg <= state_next;
    cap_reg <= cap_next;
    active_reg <= active_next;
  end
  assign cap = cap_reg;
  assign active = active_reg;
  // ***************************
  // line drive
  // ***************************
  // value and enables launch together, one clock after the request
  // pads do the tri-state; low enable means released
  php_bus_type out_reg, out_next;
  logic ad_oe_reg, ad_oe_next, cbe_oe_reg, cbe_oe_next;
  always_comb begin
    out_next = tx_bus;
    ad_oe_next = drive_addr || drive_data; // [RULE5]
    cbe_oe_next = drive_addr || drive_data; // [RULE6]
    if (hold_rst) begin
      out_next.ad = `PHP_AD_RST;
      out_next.cbe = `PHP_CBE_RST;
      ad_oe_next = 1'b0; // [RULE2]
      cbe_oe_next = 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    out_reg <= out_next;
    ad_oe_reg <= ad_oe_next;
    cbe_oe_reg <= cbe_oe_next;
  end
  assign bus_out = out_reg;
  assign ad_oe = ad_oe_reg;
  assign cbe_oe = cbe_oe_reg;
  // ***************************
  // parity
  // ***************************
  // parity covers whatever sat on the lines last clock
  php_parity u_par (
    .clk(clk),
    .hold_rst(hold_rst),
    .bus_in(bus_in),
    .drive_en(par_resp), // [RULE8]
    .par_out(par_out),
    .par_oe(par_oe)
  );
  // ***************************
  // checks
  // ***************************
  reset_quiet_a: assert property (@(posedge clk) // [RULE2]
    hold_rst |=> !ad_oe && !cbe_oe && !par_oe && cap == '0
      && bus_out == '0 && !active)
    else $error("drivers active in reset");
  resume_idle_a: assert property (@(posedge clk) // [RULE3]
    $fell(hold_rst) |-> state_reg == PHP_IDLE)
    else $error("not idle after reset");
  state_hot_a: assert property (@(posedge clk) // [RULE3]
    disable iff (!reset_n) $onehot(state_reg))
    else $error("state not one-hot");
  suspend_keep_a: assert property (@(posedge clk) // [RULE4]
    disable iff (!reset_n)
    (suspend_en && !rst_s2_reg && !addr_phase && !data_phase)
    |=> cap.addr == $past(cap.addr)
      && cap.data == $past(cap.data))
    else $error("suspend lost state");
  addr_cap_a: assert property (@(posedge clk) // [RULE5]
    disable iff (hold_rst)
    addr_phase |=> cap.addr_valid && cap.addr == $past(bus_in.ad)
      && cap.cmd == $past(bus_in.cbe))
    else $error("address capture wrong");
  data_cap_a: assert property (@(posedge clk) // [RULE6]
    disable iff (hold_rst)
    (data_phase && !addr_phase) |=> cap.data_valid
      && cap.data == $past(bus_in.ad) && cap.be == $past(bus_in.cbe))
    else $error("data capture wrong");
  addr_wins_a: assert property (@(posedge clk) // [RULE6]
    disable iff (hold_rst)
    (addr_phase && data_phase) |=> cap.addr_valid && !cap.data_valid)
    else $error("data taken in address phase");
  lane_map_a: assert property (@(posedge clk) // [RULE7]
    disable iff (hold_rst)
    cap.data_valid |-> cap.lane_mask[7:0] == {8{!cap.be[0]}}
      && cap.lane_mask[15:8] == {8{!cap.be[1]}}
      && cap.lane_mask[23:16] == {8{!cap.be[2]}}
      && cap.lane_mask[31:24] == {8{!cap.be[3]}})
    else $error("lane mask wrong");
  valid_pulse_a: assert property (@(posedge clk) // [RULE5]
    disable iff (hold_rst)
    !addr_phase && !data_phase |=> !cap.addr_valid && !cap.data_valid)
    else $error("capture valid without phase");
  data_hold_a: assert property (@(posedge clk) // [RULE5]
    disable iff (hold_rst)
    !hold_rst && !data_phase |=> cap.data == $past(cap.data)
      && cap.be == $past(cap.be) && cap.lane_mask == $past(cap.lane_mask))
    else $error("data fields changed without data phase");
  active_flag_a: assert property (@(posedge clk) // [RULE3]
    disable iff (hold_rst)
    !hold_rst |=> active == $past(addr_phase || data_phase))
    else $error("active flag wrong");
  drive_out_a: assert property (@(posedge clk) // [RULE5]
    disable iff (hold_rst)
    !hold_rst && (drive_addr || drive_data) |=> ad_oe && cbe_oe
      && bus_out == $past(tx_bus))
    else $error("bus drive wrong");
  drive_idle_a: assert property (@(posedge clk) // [RULE6]
    disable iff (hold_rst)
    !drive_addr && !drive_data |=> !ad_oe && !cbe_oe)
    else $error("bus driven without request");
  par_idle_a: assert property (@(posedge clk) // [RULE9]
    disable iff (hold_rst)
    !par_resp |=> !par_oe)
    else $error("parity driven when not owner");
  par_late_a: assert property (@(posedge clk) // [RULE8]
    disable iff (hold_rst)
    par_resp |=> par_oe
      && par_out == ^{$past(bus_in.ad), $past(bus_in.cbe)})
    else $error("parity late or wrong");
  sync_rst_a: assert property (@(posedge clk) // [RULE1]
    disable iff (!reset_n)
    (!host_bus_reset_n && !suspend_en) [*3] |-> hold_rst)
    else $error("bus reset not taken");
endmodule

// File: tb/php_host_model.sv
// Purpose: host side model driving the shared bus lines
// Assumes: bench sets go and val just after a falling edge
// Notes: released lines show the inverted last value
`timescale 1ns/1ps
module php_host_model (
  input wire logic clk,
  input wire logic go,
  input wire php_pkg::php_bus_type val,
  output php_pkg::php_bus_type bus_in
);
  import php_pkg::*;
  php_bus_type last_reg = '0;
  // *****
  // drive
  // *****
  // released lines must not keep the old value, so a held sample shows
  assign bus_in = go ? val : ~last_reg;
  always @(posedge clk) begin
    if (go) begin
      last_reg <= val;
    end
  end
endmodule

// File: tb/testbench.sv
// Purpose: self-checking bench for the host bus port core
// Assumes: inputs change at the falling edge
// Notes: one task per scenario
`timescale 1ns/1ps
module testbench;
  import php_pkg::*;
  logic clk = 0, reset_n = 0, hrst_n = 1, susp = 0;
  logic ap = 0, dp = 0, da = 0, dd = 0, pr = 0, go = 0;
  php_bus_type val = '0, tx = '0, bus_in, bus_out;
  php_cap_type cap;
  logic ad_oe, cbe_oe, par_out, par_oe, active;
  int miscompares = 0, check_count = 0, cycles = 0;
  initial forever #5 clk = ~clk;
  php_host_model host (.clk(clk), .go(go), .val(val), .bus_in(bus_in));
  php_core dut (.clk(clk), .reset_n(reset_n), .host_bus_reset_n(hrst_n),
    .suspend_en(susp), .addr_phase(ap), .data_phase(dp),
    .drive_addr(da), .drive_data(dd), .par_resp(pr), .bus_in(bus_in),
    .tx_bus(tx), .bus_out(bus_out), .ad_oe(ad_oe), .cbe_oe(cbe_oe),
    .par_out(par_out), .par_oe(par_oe), .cap(cap), .active(active));
  // *******
  // helpers
  // *******
  task chk(string what, logic [109:0] exp, logic [109:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // one phase on the bus; outputs are settled when this returns
  task cyc(logic a, logic d, logic p, php_bus_type v);
    @(negedge clk);
    ap = a; dp = d; pr = p; go = a | d | p; val = v;
    @(negedge clk);
    ap = 0; dp = 0; pr = 0; go = 0;
  endtask
  // *********
  // scenarios
  // *********
  task t_addr;
    cyc(1, 0, 0, {32'h1234_5678, 4'h7});
    chk("addr", 110'(32'h1234_5678), 110'(cap.addr));
    chk("cmd", 110'(4'h7), 110'(cap.cmd));
    chk("addr_valid", 110'(1'b1), 110'(cap.addr_valid));
    chk("active", 110'(1'b1), 110'(active));
    // both strobes up: the address phase is taken
    cyc(1, 1, 0, {32'h89ab_cdef, 4'h6});
    chk("addr both", 110'(32'h89ab_cdef), 110'(cap.addr));
    chk("cmd both", 110'(4'h6), 110'(cap.cmd));
    chk("data_valid both", 110'(1'b0), 110'(cap.data_valid));
    $display("addr phase test done");
  endtask
  task t_data;
    cyc(0, 1, 0, {32'h0102_0304, 4'h5});
    chk("lanes 1 3", 110'(32'hff00_ff00), 110'(cap.lane_mask));
    cyc(0, 1, 0, {32'hcafe_f00d, 4'ha});
    chk("data", 110'(32'hcafe_f00d), 110'(cap.data));
    chk("be", 110'(4'ha), 110'(cap.be));
    chk("lanes", 110'(32'h00ff_00ff), 110'(cap.lane_mask));
    chk("data_valid", 110'(1'b1), 110'(cap.data_valid));
    $display("data phase test done");
  endtask
  task t_par;
    php_bus_type v;
    for (int i = 0; i < 2; i++) begin
      v = {32'h0000_0001 << i | 32'h1, 4'h0};
      cyc(0, 0, 1, v);
      chk("par_oe", 110'(1'b1), 110'(par_oe));
      chk("par_out", 110'(^v), 110'(par_out));
      @(negedge clk);
      chk("par_oe off", 110'(1'b0), 110'(par_oe));
    end
    chk("active idle", 110'(1'b0), 110'(active));
    $display("parity test done");
  endtask
  task t_rst;
    da = 1; tx = {32'h5a5a_0ff0, 4'h3};
    repeat (2) @(negedge clk);
    chk("bus_out", 110'(tx), 110'(bus_out));
    chk("cbe_oe", 110'(1'b1), 110'(cbe_oe));
    susp = 1; hrst_n = 0;
    repeat (5) @(negedge clk);
    chk("kept data", 110'(32'hcafe_f00d), 110'(cap.data));
    chk("kept oe", 110'(1'b1), 110'(ad_oe));
    susp = 0;
    repeat (4) @(negedge clk);
    chk("oe in reset", 110'(1'b0), 110'(ad_oe));
    chk("cap in reset", '0, 110'(cap));
    chk("cbe_oe in reset", 110'(1'b0), 110'(cbe_oe));
    chk("active in reset", 110'(1'b0), 110'(active));
    hrst_n = 1;
    repeat (5) @(negedge clk);
    chk("oe after", 110'(1'b1), 110'(ad_oe));
    da = 0; dd = 1;
    repeat (2) @(negedge clk);
    chk("oe data", 110'(1'b1), 110'(ad_oe));
    dd = 0;
    repeat (2) @(negedge clk);
    chk("oe released", 110'(1'b0), 110'(cbe_oe));
    $display("reset test done");
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles > 2000) begin
      miscompares++;
      close_out;
    end
  end
  initial begin
    repeat (4) @(negedge clk);
    reset_n = 1;
    t_addr;
    t_data;
    t_par;
    t_rst;
    close_out;
  end
endmodule
